// ==== cam_pkg.sv ====
package cam_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_AUDIO = 4'h0;
	localparam logic [3:0] OFS_TRAV = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_TRAV_LEFT = 4'hC;

	// ----------------------------------------------------------------
	// audio control word, nibble 1 in the top bits
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] zero;
		logic mute;
		logic att_12db;
		logic meter_ctrl_hi;
		logic meter_ctrl_lo;
		logic dac_master_clock_select;
		logic sense_routing_select;
		logic dc_offset_disable;
		logic forced_mute;
		logic bass_boost_enable;
		logic bass_boost_level;
		logic atten_channel_select;
		logic [10:0] atten_value;
	} cam_cfg_t;

	localparam cam_cfg_t CFG_RST = '0;
	localparam int AUDIO_W = 24;
	localparam int TRAV_W = 16;
	localparam logic [10:0] ATTEN_UNITY = 11'h400;
	localparam logic [10:0] ATTEN_RST = 11'h400;
	localparam int ATTEN_SHIFT = 10;

	// status word field positions
	localparam int ST_METER_LSB = 0;
	localparam int ST_FLAG = 16;
	localparam int ST_DONE = 17;
	localparam int ST_MUTE = 18;
	localparam int ST_ZC_WAIT = 19;

	// ----------------------------------------------------------------
	// meter readout
	// ----------------------------------------------------------------
	localparam int RD_BITS = 96;
	localparam int SUBQ_BITS = 80;
	localparam int ABS_TIME_BITS = 24;
	localparam int PCM_ABS_W = 15;
	localparam logic [6:0] RD_LAST = 7'd95;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_LEVEL = 2'b01,
		MODE_PEAK = 2'b10,
		MODE_NORMAL2 = 2'b11
	} cam_mode_t;

	// sense pin source when not routed to the readout
	localparam logic [1:0] SENSE_EXT = 2'h0;
	localparam logic [1:0] SENSE_COMP = 2'h1;
	localparam logic [1:0] SENSE_TRACK_CROSS_COUNT = 2'h2;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int ZC_LIMIT_MS = 1;
	localparam int SYNC_LOSS_MS = 35;
	localparam int ZC_LIMIT_CYC = ZC_LIMIT_MS * (CLK_HZ / 1000);
	localparam int SYNC_LOSS_CYC = SYNC_LOSS_MS * (CLK_HZ / 1000);
	localparam int TMR_W = 19;

endpackage

// ==== cam_audio_ctrl.sv ====
// Behaviour
// - mute on mute bit, mute pin, digital-out mute, bilingual both, peak mode.
// - mute when frame sync good low over 35 ms at normal speed.
// - first three causes and sync loss wait for zero cross, forced after 1 ms.
// - meter bits pick normal, level or peak; first bit gives double C2.
// - level readout is 80 subcode bits then 15-bit value and flag, LSB first.
// - channel flag high for left channel value, low for right.
// - level readout end clears value and toggles flag; tracking resumes; a sample arriving then with flag high loads the right value.
// - peak mode tracks maximum of both channels; readout keeps it.
// - peak value cleared by meter bits both zero or mute bit write.
// - peak mode holds absolute time of first good-CRC frame after new max.
// - peak mode readout ends with flag bit zero.
// - peak mode forces hold and interpolation to minus infinity.
// - master clock select bit picks 768Fs or 384Fs crystal.
// - routing bit puts readout on sense pin, clock from command clock.
// - third nibble holds DC offset off, forced mute, bass boost, level.
// - 11-bit attenuation per channel, select bit; common mode uses left.
// - gain is value over 1024; zero silent, 400H unity; values above 400H are held at unity.
// - traverse command loads 16-bit count, first nibble top bit is MSB.
// - fine search sled control off once programmed tracks counted.
// - traverse compare and crossing count shown on sense pin.
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module cam_audio_ctrl #(
	parameter int ZC_CYC = cam_pkg::ZC_LIMIT_CYC,
	parameter int SYNC_CYC = cam_pkg::SYNC_LOSS_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [cam_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic readout_clock,
	input wire logic cmd_clock,
	input wire logic mute_pin,
	input wire logic frame_sync_good,
	input wire logic digital_out_enable_pin,
	input wire logic dout_mute_flag,
	input wire logic normal_speed,
	input wire logic bilingual_main_select,
	input wire logic bilingual_sub_select,
	input wire logic common_atten_mode,
	input wire logic zero_cross,
	input wire logic pcm_valid,
	input wire logic [15:0] pcm_left,
	input wire logic [15:0] pcm_right,
	input wire logic [cam_pkg::SUBQ_BITS-1:0] subq_data,
	input wire logic subq_crc_ok,
	input wire logic track_cross,
	input wire logic fine_search,
	input wire logic [1:0] sense_sel,
	input wire logic sense_in,
	output logic readout_serial_out,
	output logic sense_output,
	output logic audio_mute,
	output cam_pkg::cam_cfg_t cfg,
	output logic c2_double,
	output logic hold_interp_min_inf,
	output logic [10:0] atten_left,
	output logic [10:0] atten_right,
	output logic [15:0] pcm_out_left,
	output logic [15:0] pcm_out_right,
	output logic track_count_done,
	output logic track_cross_count,
	output logic sled_traverse_off
);
	import cam_pkg::*;
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [14:0] abs15(input logic [15:0] s);
		logic [15:0] n;
		n = s[15] ? (~s + 16'h0001) : s;
		return n[15] ? 15'h7FFF : n[14:0];
	endfunction

	function automatic logic [14:0] rev15(input logic [14:0] v);
		return {<<{v}};
	endfunction

	function automatic logic [15:0] scale(input logic [15:0] s,
		input logic [10:0] a);
		logic [10:0] ac;
		logic signed [27:0] p;
		ac = (a > ATTEN_UNITY) ? ATTEN_UNITY : a;
		p = 28'(signed'(s) * signed'({1'b0, ac}));
		return p[ATTEN_SHIFT+15:ATTEN_SHIFT];
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers, change taken when stages two and three agree
	// ----------------------------------------------------------------
	localparam int NP = 5;
	logic [NP-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q, pin_d;
	assign pin_raw = {readout_clock, cmd_clock, mute_pin, frame_sync_good,
		digital_out_enable_pin};
	assign pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			// stages start at the filtered level, no false edge
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
			pin_q <= {NP{1'b1}};
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= pin_d;
		end
	end

	wire rclk_pin = pin_q[4];
	wire cclk_pin = pin_q[3];
	wire mute_in = pin_q[2];
	wire fsg_in = pin_q[1];
	wire dout_en = pin_q[0];

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	cam_cfg_t cfg_q, wcfg;
	logic [TRAV_W-1:0] trav_q;
	logic [10:0] att_l_q, att_r_q;
	logic [31:0] rdata_q, rd_mux;
	assign wcfg = cam_cfg_t'(reg_wdata[AUDIO_W-1:0]);
	wire wr_audio = reg_wr && reg_addr == OFS_AUDIO;
	wire wr_trav = reg_wr && reg_addr == OFS_TRAV;
	wire mute_wr = wr_audio && wcfg.mute;
	wire [1:0] mode = {cfg_q.meter_ctrl_hi, cfg_q.meter_ctrl_lo};
	wire level_mode = mode == MODE_LEVEL;
	wire peak_mode = mode == MODE_PEAK;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q <= CFG_RST;
			att_l_q <= ATTEN_RST;
			att_r_q <= ATTEN_RST;
		end else if (wr_audio) begin
			cfg_q <= wcfg;
			if (wcfg.atten_channel_select) begin
				att_r_q <= wcfg.atten_value;
			end else begin
				att_l_q <= wcfg.atten_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// mute gathering
	// ----------------------------------------------------------------
	logic [TMR_W-1:0] sync_tmr_q, zc_tmr_q;
	logic zc_mute_q, mute_q;
	localparam logic [TMR_W-1:0] SYNC_LIM = TMR_W'(SYNC_CYC);
	localparam logic [TMR_W-1:0] ZC_LAST = TMR_W'(ZC_CYC - 1);
	wire sync_lost = sync_tmr_q >= SYNC_LIM;
	wire cause_zc = cfg_q.mute | mute_in | (dout_mute_flag & dout_en) |
		sync_lost;
	wire cause_now = (bilingual_main_select & bilingual_sub_select) |
		peak_mode;
	wire zc_fire = zero_cross || zc_tmr_q == ZC_LAST;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sync_tmr_q <= '0;
		end else if (fsg_in || !normal_speed) begin
			sync_tmr_q <= '0;
		end else if (!sync_lost) begin
			sync_tmr_q <= sync_tmr_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			zc_tmr_q <= '0;
			zc_mute_q <= 1'b0;
		end else if (!cause_zc) begin
			zc_tmr_q <= '0;
			zc_mute_q <= 1'b0;
		end else if (!zc_mute_q) begin
			zc_mute_q <= zc_fire;
			zc_tmr_q <= zc_fire ? zc_tmr_q : zc_tmr_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mute_q <= 1'b1;
		end else begin
			mute_q <= zc_mute_q | cause_now;
		end
	end

	// ----------------------------------------------------------------
	// level and peak meter
	// ----------------------------------------------------------------
	logic [14:0] meter_q;
	logic flag_q, abs_pend_q;
	logic [ABS_TIME_BITS-1:0] abs_q;
	logic [6:0] bit_q;
	logic [RD_BITS-1:0] sreg_q;
	logic rclk_prev_q;
	wire [14:0] abs_l = abs15(pcm_left);
	wire [14:0] abs_r = abs15(pcm_right);
	wire [14:0] lvl_s = flag_q ? abs_l : abs_r;
	wire [14:0] pk_s = (abs_l > abs_r) ? abs_l : abs_r;
	wire [14:0] smp = peak_mode ? pk_s : lvl_s;
	wire new_max = pcm_valid && (level_mode || peak_mode) && smp > meter_q;
	wire rclk = cfg_q.sense_routing_select ? cclk_pin : rclk_pin;
	wire rise = rclk && !rclk_prev_q;
	wire rd_done = rise && bit_q == RD_LAST;
	wire peak_clr = mode == MODE_NORMAL || mute_wr;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meter_q <= '0;
			flag_q <= 1'b1;
		end else if (peak_clr) begin
			meter_q <= '0;
		end else if (rd_done && level_mode) begin
			meter_q <= (pcm_valid && flag_q) ? abs_r : '0;
			flag_q <= !flag_q;
		end else if (new_max) begin
			meter_q <= smp;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			abs_pend_q <= 1'b0;
			abs_q <= '0;
		end else if (!peak_mode) begin
			abs_pend_q <= 1'b0;
			abs_q <= subq_data[ABS_TIME_BITS-1:0];
		end else begin
			if (subq_crc_ok && abs_pend_q) begin
				abs_q <= subq_data[ABS_TIME_BITS-1:0];
			end
			abs_pend_q <= new_max || (abs_pend_q && !subq_crc_ok);
		end
	end

	// ----------------------------------------------------------------
	// serial readout, advances on each rising edge of the readout clock, or of the command clock when routed to the sense pin
	// ----------------------------------------------------------------
	wire flag_bit = level_mode ? flag_q : 1'b0;
	wire [14:0] meter_out = (level_mode || peak_mode) ? meter_q : '0;
	wire [RD_BITS-1:0] rd_word = {subq_data[SUBQ_BITS-1:ABS_TIME_BITS],
		abs_q, rev15(meter_out), flag_bit};

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rclk_prev_q <= 1'b1;
			bit_q <= '0;
			sreg_q <= '0;
		end else begin
			rclk_prev_q <= rclk;
			if (rd_done) begin
				bit_q <= '0;
			end else if (rise) begin
				bit_q <= bit_q + 1'b1;
				sreg_q <= {sreg_q[RD_BITS-2:0], 1'b0};
			end else if (bit_q == '0) begin
				sreg_q <= rd_word;
			end
		end
	end

	// ----------------------------------------------------------------
	// traverse monitor count
	// ----------------------------------------------------------------
	logic done_q, track_cross_count_q;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			trav_q <= '0;
			done_q <= 1'b0;
			track_cross_count_q <= 1'b0;
		end else if (wr_trav) begin
			trav_q <= reg_wdata[TRAV_W-1:0];
			done_q <= 1'b0;
		end else if (track_cross) begin
			track_cross_count_q <= !track_cross_count_q;
			if (trav_q != '0) begin
				trav_q <= trav_q - 1'b1;
				done_q <= trav_q == 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux and registered outputs
	// ----------------------------------------------------------------
	logic [31:0] status;
	assign status = {12'h000, zc_tmr_q != '0 && !zc_mute_q, mute_q,
		done_q, flag_q, 1'b0, meter_q};
	assign rd_mux = (reg_addr == OFS_AUDIO) ? {8'h00, cfg_q} :
		(reg_addr == OFS_STATUS) ? status :
		(reg_addr == OFS_TRAV_LEFT) ? {16'h0000, trav_q} : 32'h0000_0000;
	wire [10:0] att_r_eff = common_atten_mode ? att_l_q : att_r_q;
	wire mute_all = mute_q | cfg_q.forced_mute;
	wire sense_d = cfg_q.sense_routing_select ? sreg_q[RD_BITS-1] :
		(sense_sel == SENSE_COMP) ? done_q :
		(sense_sel == SENSE_TRACK_CROSS_COUNT) ? track_cross_count_q : sense_in;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= '0;
			readout_serial_out <= 1'b0;
			sense_output <= 1'b0;
			audio_mute <= 1'b1;
			atten_left <= ATTEN_RST;
			atten_right <= ATTEN_RST;
			pcm_out_left <= '0;
			pcm_out_right <= '0;
			sled_traverse_off <= 1'b0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : '0;
			readout_serial_out <= sreg_q[RD_BITS-1];
			sense_output <= sense_d;
			audio_mute <= mute_all;
			atten_left <= att_l_q;
			atten_right <= att_r_eff;
			sled_traverse_off <= fine_search && done_q;
			if (pcm_valid) begin
				pcm_out_left <= mute_all ? '0 : scale(pcm_left, att_l_q);
				pcm_out_right <= mute_all ? '0 : scale(pcm_right, att_r_eff);
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign cfg = cfg_q;
	assign c2_double = cfg_q.meter_ctrl_hi;
	assign hold_interp_min_inf = cfg_q.meter_ctrl_hi &&
		!cfg_q.meter_ctrl_lo;
	assign track_count_done = done_q;
	assign track_cross_count = track_cross_count_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_last_bit;
		rise && bit_q == RD_LAST;
	endsequence
	property p_now_mute;
		cause_now |=> ##1 audio_mute;
	endproperty
	a_now_mute: assert property (p_now_mute) else $error("no mute");
	property p_zc_force;
		(cause_zc && !zc_mute_q && zc_tmr_q == ZC_LAST) ##1 cause_zc
		|-> zc_mute_q ##1 mute_q;
	endproperty
	a_zc_force: assert property (p_zc_force) else $error("late mute");
	property p_zc_bound;
		zc_tmr_q <= ZC_LAST;
	endproperty
	a_zc_bound: assert property (p_zc_bound) else $error("zc timer");
	property p_sync_loss;
		(sync_tmr_q == SYNC_LIM - 1'b1 && !fsg_in && normal_speed)
		|=> cause_zc;
	endproperty
	a_sync_loss: assert property (p_sync_loss) else $error("sync");
	property p_level_end;
		(s_last_bit and (level_mode && !pcm_valid && !peak_clr))
		|=> meter_q == '0 && flag_q != $past(flag_q);
	endproperty
	a_level_end: assert property (p_level_end) else $error("level");
	property p_peak_keep;
		(s_last_bit and (peak_mode && !pcm_valid && !mute_wr))
		|=> meter_q == $past(meter_q);
	endproperty
	a_peak_keep: assert property (p_peak_keep) else $error("peak");
	property p_peak_clr;
		mute_wr |=> meter_q == '0;
	endproperty
	a_peak_clr: assert property (p_peak_clr) else $error("clear");
	property p_count;
		s_last_bit |=> bit_q == '0 ##1 bit_q == '0 && sreg_q == $past(rd_word);
	endproperty
	a_count: assert property (p_count) else $error("count");
	property p_route;
		cfg_q.sense_routing_select |=> sense_output == $past(sreg_q[95]);
	endproperty
	a_route: assert property (p_route) else $error("route");
	property p_done;
		(track_cross && !wr_trav && trav_q == 16'h0001 && fine_search)
		|=> done_q ##1 sled_traverse_off == $past(fine_search);
	endproperty
	a_done: assert property (p_done) else $error("traverse");

endmodule

`default_nettype wire

// ==== cam_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module cam_host_model (
	input wire logic start,
	input wire logic use_cmd,
	input wire logic sdata,
	output logic readout_clock,
	output logic cmd_clock,
	output logic busy,
	output logic [95:0] word
);
	// ----
	// host side of the meter readout link
	// ----
	initial begin
		readout_clock = 1'b1;
		cmd_clock = 1'b1;
		busy = 1'b0;
		word = '0;
	end

	// both clocks stay high between frames
	always @(posedge start) begin
		busy = 1'b1;
		#37;
		for (int i = 0; i < 96; i++) begin
			if (use_cmd) begin
				cmd_clock = 1'b0;
			end else begin
				readout_clock = 1'b0;
			end
			#400;
			word = {word[94:0], sdata};
			if (use_cmd) begin
				cmd_clock = 1'b1;
			end else begin
				readout_clock = 1'b1;
			end
			#400;
		end
		busy = 1'b0;
	end
endmodule
`default_nettype wire

// ==== cam_audio_ctrl_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module cam_audio_ctrl_tb;
	import cam_pkg::*;
	logic clk_sys, sys_rst, reg_wr, reg_rd, readout_clock, cmd_clock;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, s;
	logic mute_pin, frame_sync_good, digital_out_enable_pin, dout_mute_flag;
	logic normal_speed, bilingual_main_select, bilingual_sub_select;
	logic common_atten_mode, zero_cross, pcm_valid, subq_crc_ok, track_cross;
	logic fine_search, sense_in, readout_serial_out, sense_output, audio_mute;
	logic c2_double, hold_interp_min_inf, track_count_done, track_cross_count;
	logic sled_traverse_off, start, use_cmd, busy, f0;
	logic [1:0] sense_sel;
	logic [15:0] pcm_left, pcm_right, pcm_out_left, pcm_out_right;
	logic [10:0] atten_left, atten_right;
	logic [79:0] subq_data;
	logic [95:0] word, w;
	cam_cfg_t cfg, c;
	int num_errors, tests_run;

	cam_audio_ctrl #(.ZC_CYC(20), .SYNC_CYC(50)) cam_audio_ctrl_inst (
		.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .readout_clock, .cmd_clock, .mute_pin, .frame_sync_good,
		.digital_out_enable_pin, .dout_mute_flag, .normal_speed,
		.bilingual_main_select, .bilingual_sub_select, .common_atten_mode,
		.zero_cross, .pcm_valid, .pcm_left, .pcm_right, .subq_data,
		.subq_crc_ok, .track_cross, .fine_search, .sense_sel, .sense_in,
		.readout_serial_out, .sense_output, .audio_mute, .cfg, .c2_double,
		.hold_interp_min_inf, .atten_left, .atten_right, .pcm_out_left,
		.pcm_out_right, .track_count_done, .track_cross_count,
		.sled_traverse_off);

	cam_host_model cam_host_model_inst (.start, .use_cmd,
		.sdata(use_cmd ? sense_output : readout_serial_out),
		.readout_clock, .cmd_clock, .busy, .word);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		#4_000_000;
		num_errors++;
		finish_test();
	end

	// ----
	// bus, link and compare tasks
	// ----
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		d = reg_rdata;
	endtask

	task automatic au(input cam_cfg_t v);
		wr(OFS_AUDIO, {8'h00, v});
	endtask

	task automatic mode(input logic [1:0] m);
		c.meter_ctrl_hi = m[1];
		c.meter_ctrl_lo = m[0];
		au(c);
	endtask

	task automatic pcm(input logic [15:0] l, input logic [15:0] r);
		@(posedge clk_sys);
		pcm_left <= l;
		pcm_right <= r;
		pcm_valid <= 1'b1;
		@(posedge clk_sys);
		pcm_valid <= 1'b0;
	endtask

	task automatic readout(input logic cmd, output logic [95:0] q);
		@(posedge clk_sys);
		use_cmd <= cmd;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		for (int k = 0; k < 1000 && busy; k++) @(posedge clk_sys);
		chk(busy, 1'b0);
		cyc(10);
		q = word;
	endtask

	task automatic cause(input int k, input logic v);
		@(posedge clk_sys);
		case (k)
			0: begin
				c.mute = v;
				au(c);
			end
			1: mute_pin <= v;
			2: digital_out_enable_pin <= v;
			3: begin
				bilingual_main_select <= v;
				bilingual_sub_select <= v;
			end
			default: mode({v, 1'b0});
		endcase
	endtask

	function automatic logic [95:0] exp_word(input logic [79:0] q,
		input logic [14:0] v, input logic f);
		logic [14:0] r;
		for (int i = 0; i < 15; i++) r[i] = v[14-i];
		return {q, r, f};
	endfunction

	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----
	// test sequence
	// ----
	initial begin
		{reg_wr, reg_rd, mute_pin, dout_mute_flag, digital_out_enable_pin} = '0;
		{bilingual_main_select, bilingual_sub_select, common_atten_mode} = '0;
		{pcm_valid, subq_crc_ok, track_cross, fine_search, sense_in} = '0;
		{start, use_cmd, frame_sync_good, normal_speed, zero_cross} = 5'h07;
		reg_addr = '0;
		reg_wdata = '0;
		sense_sel = '0;
		pcm_left = '0;
		pcm_right = '0;
		subq_data = 80'h0123456789ABCDEF1357;
		sys_rst = 1'b1;
		c = CFG_RST;
		c.atten_value = ATTEN_UNITY;
		repeat (8) @(posedge clk_sys);
		chk(audio_mute, 1'b1);
		chk(atten_left, ATTEN_RST);
		sys_rst <= 1'b0;
		rd(4'h2, s);
		chk(s, 32'h0);
		chk(cfg, CFG_RST);
		c.dac_master_clock_select = 1'b1;
		c.dc_offset_disable = 1'b1;
		c.bass_boost_enable = 1'b1;
		c.bass_boost_level = 1'b1;
		au(c);
		rd(OFS_AUDIO, s);
		chk(s, {8'h00, c});
		chk(cfg, c);
		c.forced_mute = 1'b1;
		au(c);
		cyc(8);
		chk(audio_mute, 1'b1);
		c = CFG_RST;
		c.atten_value = ATTEN_UNITY;
		au(c);
		dout_mute_flag <= 1'b1;
		cyc(8);
		chk(audio_mute, 1'b0);
		for (int k = 0; k < 5; k++) begin
			cause(k, 1'b1);
			cyc(8);
			chk(audio_mute, 1'b1);
			cause(k, 1'b0);
			cyc(8);
			chk(audio_mute, 1'b0);
		end
		dout_mute_flag <= 1'b0;
		zero_cross <= 1'b0;
		mute_pin <= 1'b1;
		cyc(10);
		chk(audio_mute, 1'b0);
		cyc(25);
		chk(audio_mute, 1'b1);
		mute_pin <= 1'b0;
		zero_cross <= 1'b1;
		frame_sync_good <= 1'b0;
		cyc(30);
		chk(audio_mute, 1'b0);
		cyc(35);
		chk(audio_mute, 1'b1);
		frame_sync_good <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			mode(m[1:0]);
			cyc(2);
			chk(c2_double, m[1]);
			chk(hold_interp_min_inf, m == 2);
		end
		mode(2'b01);
		rd(OFS_STATUS, s);
		f0 = s[ST_FLAG];
		pcm(16'hFED4, 16'h03E8);
		readout(1'b0, w);
		chk(w, exp_word(subq_data, f0 ? 15'h12C : 15'h3E8, f0));
		rd(OFS_STATUS, s);
		chk(s[14:0], 15'h0);
		chk(s[ST_FLAG], !f0);
		pcm(16'hFED4, 16'h03E8);
		readout(1'b0, w);
		chk(w, exp_word(subq_data, f0 ? 15'h3E8 : 15'h12C, ~f0));
		mode(2'b10);
		pcm(16'h01F4, 16'hF830);
		@(posedge clk_sys);
		subq_crc_ok <= 1'b1;
		@(posedge clk_sys);
		subq_crc_ok <= 1'b0;
		subq_data[23:0] <= 24'h55AA33;
		readout(1'b0, w);
		chk(w, exp_word({subq_data[79:24], 24'hEF1357}, 15'h7D0, 1'b0));
		c.sense_routing_select = 1'b1;
		au(c);
		readout(1'b1, w);
		chk(w, exp_word({subq_data[79:24], 24'hEF1357}, 15'h7D0, 1'b0));
		c.sense_routing_select = 1'b0;
		au(c);
		sense_in <= 1'b1;
		cyc(4);
		chk(sense_output, 1'b1);
		mode(2'b00);
		rd(OFS_STATUS, s);
		chk(s[14:0], 15'h0);
		mode(2'b10);
		pcm(16'h01F4, 16'h0000);
		c.mute = 1'b1;
		au(c);
		rd(OFS_STATUS, s);
		chk(s[14:0], 15'h0);
		c.mute = 1'b0;
		mode(2'b00);
		c.atten_value = 11'h200;
		au(c);
		c.atten_channel_select = 1'b1;
		c.atten_value = 11'h100;
		au(c);
		pcm(16'h03E8, 16'h03E8);
		cyc(2);
		chk(atten_left, 11'h200);
		chk(atten_right, 11'h100);
		chk(pcm_out_left, 16'h01F4);
		chk(pcm_out_right, 16'h00FA);
		common_atten_mode <= 1'b1;
		cyc(3);
		chk(atten_right, 11'h200);
		common_atten_mode <= 1'b0;
		c.atten_channel_select = 1'b0;
		c.atten_value = 11'h000;
		au(c);
		pcm(16'h03E8, 16'h03E8);
		cyc(2);
		chk(pcm_out_left, 16'h0000);
		wr(OFS_TRAV, 32'h0000_8003);
		rd(OFS_TRAV_LEFT, s);
		chk(s[15:0], 16'h8003);
		wr(OFS_TRAV, 32'h0000_0003);
		fine_search <= 1'b1;
		sense_sel <= 2'h1;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			track_cross <= 1'b1;
			@(posedge clk_sys);
			track_cross <= 1'b0;
			cyc(3);
			chk(track_count_done, k == 2);
		end
		chk(sled_traverse_off, 1'b1);
		chk(sense_output, 1'b1);
		sense_sel <= 2'h2;
		cyc(3);
		chk(sense_output, 1'b1);
		chk(track_cross_count, 1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
